//--- rtl/rate_limit_pkg.sv
// Constants for the per-queue rate limiter of one switch port.
// Assumes a 100 MHz core clock; everything is in the core clock domain.
package rate_limit_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Setting encoding
    localparam int unsigned SETTING_W      = 7;
    localparam int unsigned QUEUES         = 4;
    localparam logic [6:0]  CODE_OFF       = 7'h00;   // No limit, reset value
    localparam logic [6:0]  CODE_MBPS_MAX  = 7'h63;   // 99 Mbps
    localparam logic [6:0]  CODE_FULL      = 7'h64;   // 100, no limit
    localparam logic [6:0]  CODE_SLOW_MIN  = 7'h65;   // 101, 64 kbps
    localparam logic [6:0]  CODE_SLOW_MAX  = 7'h73;   // 115, 960 kbps
    localparam logic [6:0]  CODE_10M_MAX   = 7'h09;   // 9 Mbps on a 10 Mbps port
    localparam int unsigned KBPS_PER_MBPS  = 1000;
    localparam int unsigned KBPS_STEP      = 64;

    ////////////////////////////////////////////////////////////////////////
    // Credit and timing
    localparam int unsigned RATE_W         = 17;      // Up to 99000 kbps
    localparam int unsigned CREDIT_W       = 20;      // Signed bit credit
    localparam int unsigned RATIO_W        = 7;
    localparam int unsigned RATIO_SHIFT    = 7;       // Ratio 128 means full rate
    localparam int unsigned LEN_W          = 11;      // Frame bytes, up to 2047
    localparam int unsigned BITS_PER_BYTE_SHIFT = 3;
    localparam int unsigned REFILL_NS      = 1000000; // One refill per 1 ms
    localparam int unsigned CLK_NS         = 10;
    localparam int unsigned REFILL_CYCLES  = REFILL_NS / CLK_NS;
    localparam int unsigned BURST_BITS     = 131072;  // Bucket ceiling

    ////////////////////////////////////////////////////////////////////////
    // Queue modes
    typedef enum logic [1:0]
    {
        QMODE_ONE  = 2'h0,
        QMODE_TWO  = 2'h1,
        QMODE_FOUR = 2'h2
    } queue_mode_t;

endpackage : rate_limit_pkg

//--- rtl/credit_bucket.sv
// One token bucket: credit in bits, refilled by pulses, spent per frame.
// Assumes refill and requests come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module credit_bucket #(
    parameter int unsigned CREDIT_W = 20,
    parameter int unsigned LEN_W    = 11,
    parameter int unsigned CAP      = 131072
) (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic                ce,
    input  wire logic                refill,
    input  wire logic [CREDIT_W-2:0] increment,
    input  wire logic                unlimited,
    input  wire logic                request,
    input  wire logic [LEN_W-1:0]    frame_bytes,
    output var  logic                grant,
    output var  logic                blocked
);

    localparam logic signed [CREDIT_W-1:0] CAP_S = CREDIT_W'(CAP);

    // Refuse sizes whose credit or frame cost would overflow the register
    if (CAP >= (1 << (CREDIT_W - 1)) || LEN_W + 3 >= CREDIT_W - 1)
    begin : g_bad_size
        $error("credit_bucket: CAP or LEN_W too large for CREDIT_W");
    end

    logic signed [CREDIT_W-1:0] credit;
    logic signed [CREDIT_W-1:0] next_credit;
    logic signed [CREDIT_W:0]   sum;
    logic                       take;

    ////////////////////////////////////////////////////////////////////////
    // Per-frame admission: a frame goes while credit is positive and may
    // drive it negative, so a big frame never waits forever (no starvation).
    assign take = request && !grant && (unlimited || credit > 0);

    always_comb
    begin
        sum = {credit[CREDIT_W-1], credit};
        if (refill)
            sum = sum + (CREDIT_W+1)'({1'b0, increment});
        if (take && !unlimited)
            sum = sum - (CREDIT_W+1)'({frame_bytes, 3'h0});
        if (unlimited)
            next_credit = '0;                          // A new limit starts empty, no burst
        else if (sum > (CREDIT_W+1)'(CAP_S))
            next_credit = CAP_S;                       // Saturate at burst ceiling
        else
            next_credit = sum[CREDIT_W-1:0];
    end

    // Credit register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            credit <= '0;
        else if (ce)
            credit <= next_credit;
    end

    // Grant pulse and stall flag
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            grant   <= 1'b0;
            blocked <= 1'b0;
        end
        else if (ce)
        begin
            grant   <= take;
            blocked <= request && !take && !grant;
        end
    end

endmodule : credit_bucket

`default_nettype wire

//--- rtl/rate_limit_code_decoder.sv
// Decodes four 7-bit queue rate settings of one port and shapes frames.
// Assumes settings, speed, mode and ratios are static registers on clk,
// and each queue holds its request with a frame length until granted.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// R1: Each queue setting is seven bits, same code for ingress and egress.
// R2: At 100 Mbps codes 1 to 99 limit to that many Mbps.
// R3: At 10 Mbps codes 1 to 9 limit to that many Mbps.
// R4: Codes 0 and 100 mean no limit; settings reset to 0.
// R5: Codes from 101 give limits in 64 kbps steps below 1 Mbps.
// R6: Software sets two- or four-queue mode before priority ingress limiting.
// R7: With several egress queues the top queue gets its exact rate.
// R8: Lower queues get bandwidth scaled by their queue ratio settings.
// R9: Each queue's frames are shaped by the rate its setting decodes to.
// R10: Undefined codes above 115 mean no limit.
module rate_limit_code_decoder #(
    parameter int unsigned REFILL_CYCLES = rate_limit_pkg::REFILL_CYCLES,
    parameter int unsigned BURST_BITS    = rate_limit_pkg::BURST_BITS
) (
    input  wire logic                                   clk,
    input  wire logic                                   rst,
    input  wire logic                                   ce,
    input  wire logic                                   speed_100,
    input  wire logic [1:0]                             queue_mode,
    input  wire logic [3:0][rate_limit_pkg::SETTING_W-1:0] queue_setting,
    input  wire logic [3:0][rate_limit_pkg::RATIO_W-1:0]   queue_ratio,
    input  wire logic [3:0]                             frame_request,
    input  wire logic [3:0][rate_limit_pkg::LEN_W-1:0]     frame_bytes,
    output var  logic [3:0]                             frame_grant,
    output var  logic [3:0]                             queue_blocked,
    output var  logic [3:0]                             queue_limited
);

    // Refuse periods the 24-bit refill counter cannot hold; a period of
    // one cycle would leave no room between pulses.
    if (REFILL_CYCLES < 2 || REFILL_CYCLES > 32'h00FF_FFFF)
    begin : g_bad_refill
        $error("rate_limit_code_decoder: REFILL_CYCLES out of range");
    end

    // Refuse a ceiling below one full-length frame, or the longest frame
    // could never find its credit after a long idle.
    if (BURST_BITS < (1 << (rate_limit_pkg::LEN_W + rate_limit_pkg::BITS_PER_BYTE_SHIFT)))
    begin : g_bad_burst
        $error("rate_limit_code_decoder: BURST_BITS below one frame");
    end

    ////////////////////////////////////////////////////////////////////////
    // Code decoding

    // Codes 10 to 99 on a 10 Mbps port would ask for at least what the wire
    // carries, so they decode as no limit rather than as a silent cap.
    // Rate in kbps for a setting, zero meaning no limit
    function automatic logic [rate_limit_pkg::RATE_W-1:0] decode_kbps(
        input logic [6:0] code,
        input logic       fast
    );
        logic [31:0] k;
        k = 32'h0000_0000;
        if (code == rate_limit_pkg::CODE_OFF || code == rate_limit_pkg::CODE_FULL)
            k = 32'h0000_0000;                                              // R4
        else if (code <= rate_limit_pkg::CODE_MBPS_MAX)
        begin
            if (fast || code <= rate_limit_pkg::CODE_10M_MAX)               // R2 R3
                k = 32'(code) * rate_limit_pkg::KBPS_PER_MBPS;
        end
        else if (code <= rate_limit_pkg::CODE_SLOW_MAX)
            k = 32'(code - rate_limit_pkg::CODE_FULL) * rate_limit_pkg::KBPS_STEP; // R5
        else
            k = 32'h0000_0000;                                              // R10
        return k[rate_limit_pkg::RATE_W-1:0];
    endfunction : decode_kbps

    // Index of the highest-priority queue in use; a reserved mode code
    // gives queue 0, as one-queue mode does, though queues 1 to 3 are still ratio-scaled.
    function automatic logic [1:0] top_queue(input logic [1:0] mode);
        logic [1:0] t;
        unique case (mode)
            rate_limit_pkg::QMODE_FOUR: t = 2'h3;
            rate_limit_pkg::QMODE_TWO:  t = 2'h1;
            default:                    t = 2'h0;
        endcase
        return t;
    endfunction : top_queue

    // Bits added per refill: exact for the top queue, ratio/128 below it.
    // A tiny ratio still yields one bit, so a lower queue slows but never
    // stops outright while its code asks for a limit.
    function automatic logic [rate_limit_pkg::CREDIT_W-2:0] scale_rate(
        input logic [rate_limit_pkg::RATE_W-1:0]  rate,
        input logic [rate_limit_pkg::RATIO_W-1:0] ratio,
        input logic                               scaled_queue
    );
        logic [31:0] s;
        s = 32'(rate);                                                      // R7
        if (scaled_queue)
            s = (32'(rate) * 32'(ratio)) >> rate_limit_pkg::RATIO_SHIFT;     // R8
        if (s == 32'h0000_0000 && rate != '0)
            s = 32'h0000_0001;                                              // Never starve fully
        return s[rate_limit_pkg::CREDIT_W-2:0];
    endfunction : scale_rate

    ////////////////////////////////////////////////////////////////////////
    // Refill timer: one pulse per refill period, shared by all queues.
    // A common pulse keeps the queues' rates in step; the cost is that a
    // burst of short frames can land just before or after a pulse, so
    // rates only hold when averaged over several periods.

    logic [23:0] refill_count;
    logic        refill;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            refill_count <= '0;
            refill       <= 1'b0;
        end
        else if (ce)
        begin
            if (refill_count == 24'(REFILL_CYCLES - 1))
            begin
                refill_count <= '0;
                refill       <= 1'b1;
            end
            else
            begin
                refill_count <= refill_count + 24'h00_0001;
                refill       <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-queue decode: rate and increment worked out combinationally,
    // then one register per concern. The multiply stays ahead of the
    // registers, so the bucket's adder sees only a flop; the price is one
    // cycle of lag after a setting changes.

    logic [3:0][rate_limit_pkg::RATE_W-1:0]   kbps;
    logic [3:0]                               scaled_queue;
    logic [3:0]                               limit_now;
    logic [3:0][rate_limit_pkg::CREDIT_W-2:0] next_increment;
    logic [3:0][rate_limit_pkg::CREDIT_W-2:0] increment;
    logic [3:0]                               unlimited;
    logic [1:0]                               top;

    assign top = top_queue(queue_mode);

    // Rate per queue; outside one-queue mode only the top queue is exempt from the ratio
    always_comb
    begin
        for (int q = 0; q < 4; q++)
        begin
            kbps[q]           = decode_kbps(queue_setting[q], speed_100);   // R1 R9
            limit_now[q]      = (kbps[q] != '0);
            scaled_queue[q]   = (2'(q) != top) && (queue_mode != rate_limit_pkg::QMODE_ONE);
            next_increment[q] = scale_rate(kbps[q], queue_ratio[q], scaled_queue[q]); // R7 R8
        end
    end

    // Bits added per refill; equal to kbps when a refill period is 1 ms.
    // Other periods scale every rate by the same factor.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            increment <= '0;
        else if (ce)
            increment <= next_increment;                                    // R7 R8
    end

    // Bucket bypass; reads unlimited in reset so no queue stalls at start.
    // Unlimited also empties the credit, so a new limit starts without burst.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            unlimited <= '1;
        else if (ce)
            unlimited <= ~limit_now;                                        // R4 R10
    end

    // Status flag for the port, one cycle behind a setting change.
    // Software reads it to see whether a code took effect at this speed.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            queue_limited <= '0;
        else if (ce)
            queue_limited <= limit_now;                                     // R2 R3 R5
    end

    ////////////////////////////////////////////////////////////////////////
    // One bucket per queue. Admission is per frame: a frame goes while
    // credit is above zero and may overdraw it, so a long frame is never
    // starved, and the debt is paid back out of later refills.

    for (genvar q = 0; q < 4; q++)
    begin : g_bucket
        credit_bucket #(
            .CREDIT_W (rate_limit_pkg::CREDIT_W),
            .LEN_W    (rate_limit_pkg::LEN_W),
            .CAP      (BURST_BITS)
        ) u_bucket (
            .clk         (clk),
            .rst         (rst),
            .ce          (ce),
            .refill      (refill),
            .increment   (increment[q]),
            .unlimited   (unlimited[q]),
            .request     (frame_request[q]),
            .frame_bytes (frame_bytes[q]),
            .grant       (frame_grant[q]),
            .blocked     (queue_blocked[q])
        );
    end

endmodule : rate_limit_code_decoder

`default_nettype wire

//--- testbench/queue_feeder.sv
// Queue scheduler model feeding the rate limiter of one port.
// Assumes frame_grant is a one-cycle pulse, settled by the falling edge.
`timescale 1ns/1ps
`default_nettype none
module queue_feeder (
    input  wire logic             clk,
    input  wire logic [3:0]       enable,
    input  wire logic [10:0]      length,
    input  wire logic [3:0]       frame_grant,
    output var  logic [3:0]       frame_request,
    output var  logic [3:0][10:0] frame_bytes,
    output var  int               grants
);
    initial frame_request = 4'h0;
    initial frame_bytes = '0;
    initial grants = 0;
    // Hold a waiting frame until granted; idle lanes show inverted length
    always @(negedge clk)
        for (int q = 0; q < 4; q++)
        begin
            if (frame_grant[q] || !frame_request[q])
                frame_request[q] <= enable[q];
            frame_bytes[q] <= (frame_request[q] && !frame_grant[q]) || enable[q] ? length : ~length;
        end
    // Count every grant pulse once
    always @(posedge clk)
        grants <= grants + $countones(frame_grant);
endmodule : queue_feeder
`default_nettype wire

//--- testbench/rate_limit_assertions.sv
// Port checker for the rate limit decoder.
// Assumes ce held high and queue 0 carrying the decode sweep.
`timescale 1ns/1ps
`default_nettype none
module rate_limit_checker (
    input wire logic            clk,
    input wire logic            rst,
    input wire logic            speed_100,
    input wire logic [3:0][6:0] queue_setting,
    input wire logic [3:0]      frame_request,
    input wire logic [3:0]      frame_grant,
    input wire logic [3:0]      queue_blocked,
    input wire logic [3:0]      queue_limited
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic [6:0] c;
    assign c = queue_setting[0];
    ////////////////////////////////////////////////////////////////////////
    // Decode flag, judged once a code has settled over four edges
    property p_fast; (speed_100 && c inside {[7'h01:7'h63]})[*4] |-> queue_limited[0]; endproperty
    a_fast: assert property (p_fast) else $error("Mbps code not limited");
    property p_slow; (c inside {[7'h01:7'h09]})[*4] |-> queue_limited[0]; endproperty
    a_slow: assert property (p_slow) else $error("low Mbps code not limited");
    property p_off; (c inside {7'h00, 7'h64})[*4] |-> !queue_limited[0]; endproperty
    a_off: assert property (p_off) else $error("off code limited");
    property p_kbps; (c inside {[7'h65:7'h73]})[*4] |-> queue_limited[0]; endproperty
    a_kbps: assert property (p_kbps) else $error("kbps code not limited");
    property p_undef; (c > 7'h73)[*4] |-> !queue_limited[0]; endproperty
    a_undef: assert property (p_undef) else $error("undefined code limited");
    ////////////////////////////////////////////////////////////////////////
    // Grants: caused by a request, never two in a row, prompt on queue 3 when unlimited
    property p_gap; (frame_grant & $past(frame_grant)) == 4'h0; endproperty
    a_gap: assert property (p_gap) else $error("grant twice in a row");
    property p_cause; ((frame_grant | queue_blocked) & ~$past(frame_request)) == 4'h0; endproperty
    a_cause: assert property (p_cause) else $error("grant without request");
    property p_top; (!queue_limited[3] && $stable(queue_setting[3]))[*4]
        ##0 (frame_request[3] && !frame_grant[3]) |=> frame_grant[3]; endproperty
    a_top: assert property (p_top) else $error("unlimited top queue stalled");
    c_grant: cover property (frame_grant[3]);
    c_block: cover property (queue_blocked[3]);
    c_limit: cover property (queue_limited[0]);
endmodule : rate_limit_checker
bind rate_limit_code_decoder rate_limit_checker i_chk (.clk(clk), .rst(rst),
    .speed_100(speed_100), .queue_setting(queue_setting), .frame_request(frame_request),
    .frame_grant(frame_grant), .queue_blocked(queue_blocked), .queue_limited(queue_limited));
`default_nettype wire

//--- testbench/tb_top.sv
// Self-checking bench for the rate limit decoder.
// Assumes a 100-cycle refill, so 1 Mbps is 1000 bits per 100 cycles.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; \
    $display("Error %s expected %0d got %0d", n, e, g); end end
module tb_top;
    logic             clk = 1'h0, rst = 1'h1, speed_100 = 1'h1;
    logic [3:0][6:0]  queue_setting = '0, queue_ratio = '0;
    logic [3:0]       en = 4'h0, frame_request, frame_grant, queue_blocked, queue_limited;
    logic [3:0][10:0] frame_bytes;
    logic [10:0]      len = 11'h07d;
    logic [1:0]       mode = 2'h2;
    int               grants, miscompares = 0, check_count = 0;
    initial forever #5 clk = ~clk;
    // Refill shortened so that rates scale by a thousand
    rate_limit_code_decoder #(.REFILL_CYCLES(100)) i_dut (.clk(clk), .rst(rst), .ce(1'h1),
        .speed_100(speed_100), .queue_mode(mode), .queue_setting(queue_setting),
        .queue_ratio(queue_ratio), .frame_request(frame_request), .frame_bytes(frame_bytes),
        .frame_grant(frame_grant), .queue_blocked(queue_blocked), .queue_limited(queue_limited));
    queue_feeder i_src (.clk(clk), .enable(en), .length(len), .frame_grant(frame_grant),
        .frame_request(frame_request), .frame_bytes(frame_bytes), .grants(grants));
    ////////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        if (miscompares == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    task automatic t_reset;
        repeat (12) @(negedge clk);
        `CHK("reset outputs", 12'h000, {frame_grant, queue_blocked, queue_limited})
        rst = 1'h0;
    endtask : t_reset
    // Every code at both speeds; four edges cover the decode lag
    task automatic t_decode;
        logic lim;
        for (int s = 0; s < 2; s++)
            for (int k = 0; k < 128; k++)
            begin
                speed_100 = s[0];
                queue_setting[0] = k[6:0];
                repeat (4) @(negedge clk);
                lim = (k >= 101 && k <= 115) || (k >= 1 && k <= (s ? 99 : 9));
                `CHK("limit flag", lim, queue_limited[0])
            end
        queue_setting[0] = 7'h00;
    endtask : t_decode
    // Fresh reset clears credit; count grants over ten refill periods
    task automatic t_rate(input int q, input logic [6:0] code, input logic spd,
        input logic [6:0] ratio, input logic [10:0] bytes, input int exp,
        input logic [1:0] md);
        int g;
        logic held;
        rst = 1'h1;
        speed_100 = spd;
        mode = md;
        queue_setting[q] = code;
        queue_ratio[q] = ratio;
        len = bytes;
        @(negedge clk);
        rst = 1'h0;
        repeat (3) @(negedge clk);
        en[q] = 1'h1;
        repeat (300) @(negedge clk);
        g = grants;
        held = 1'h0;
        repeat (1000)
        begin
            @(negedge clk);
            held |= queue_blocked[q];
        end
        g = grants - g;
        `CHK("grants", exp, (g >= exp - 2 && g <= exp + 2) ? exp : g)
        `CHK("held back", exp < 500, held)
        en[q] = 1'h0;
        repeat (200) @(negedge clk);
    endtask : t_rate
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        t_reset();
        t_decode();
        t_rate(3, 7'h05, 1'h1, 7'h00, 11'h07d, 50, 2'h2);
        t_rate(3, 7'h03, 1'h0, 7'h00, 11'h07d, 30, 2'h2);
        t_rate(3, 7'h69, 1'h1, 7'h00, 11'h008, 50, 2'h2);
        t_rate(3, 7'h64, 1'h1, 7'h00, 11'h07d, 500, 2'h2);
        t_rate(3, 7'h7b, 1'h1, 7'h00, 11'h07d, 500, 2'h2);
        t_rate(0, 7'h05, 1'h1, 7'h40, 11'h07d, 25, 2'h2);
        t_rate(1, 7'h05, 1'h1, 7'h40, 11'h07d, 50, 2'h1);
        t_rate(0, 7'h05, 1'h1, 7'h40, 11'h07d, 50, 2'h0);
        wrap_up();
    end
    // Watchdog, about twice the planned run
    initial
    begin
        repeat (30000) @(posedge clk);
        miscompares++;
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
